// ---- hdl/isf_params.svh ----
`ifndef ISF_PARAMS_SVH
`define ISF_PARAMS_SVH

// Register byte offsets
`define OFS_STATUS 8'h00
`define OFS_CLEAR 8'h04
`define OFS_MASK 8'h08
`define OFS_POLL 8'h0C
`define OFS_LV_THR 8'h10
`define OFS_OV_THR 8'h14
`define OFS_HOLD_LIM 8'h18
`define OFS_MOVE_LIM 8'h1C
`define OFS_HALT 8'h20
`define OFS_DATA3 8'h24

// Internal status word bit positions
`define BIT_INDEX 0
`define BIT_CALC_ZERO 1
`define BIT_CALC_POS 2
`define BIT_CALC_NEG 3
`define BIT_IO1 4
`define BIT_IO2 5
`define BIT_IO3 6
`define BIT_OVER_TEMP_N 7
`define BIT_MOVE_ERR 8
`define BIT_HOLD_ERR 9
`define BIT_HALT 10
`define BIT_STOP_FOUND 11
`define BIT_WAIT_DONE 12
`define BIT_OVER_V 13
`define BIT_LOW_V 14
`define BIT_RSVD 15
`define POLL_SUMMARY_BIT 6
`define CLEAR_GO_BIT 0

// Latched bits of the status word
`define LATCHED_MASK 16'h7F01

// Reset values
`define MASK_RST 15'h0000
`define LV_THR_RST 16'h0000
`define OV_THR_RST 16'hFFFF
`define LIM_RST 16'hFFFF
`define WORD_RST 16'h0000
`define DATA32_ZERO 32'h00000000
`define HALF_ZERO 16'h0000

`endif

// ---- hdl/isf_pkg.sv ----
package isf_pkg;

   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
   } sync3_state_t;

   typedef struct packed {
      logic [15:0] flags;
   } flag_state_t;

   typedef struct packed {
      logic [14:0] mask;
      logic [15:0] lv_thr;
      logic [15:0] ov_thr;
      logic [15:0] hold_lim;
      logic [15:0] move_lim;
      logic calc_neg;
      logic calc_pos;
      logic calc_zero;
      logic clr_req;
      logic halt_req;
      logic pend;
      logic pend_write;
      logic [7:0] pend_addr;
      logic hready;
      logic [31:0] hrdata;
      logic hresp;
      logic [15:0] word;
      logic summary;
   } ctl_state_t;

endpackage

// ---- hdl/flag_if.sv ----
`timescale 1ns/100ps
interface flag_if;
   logic [15:0] set;
   logic clr_all;
   logic clr_stop;
   logic [15:0] flags;

   modport bank (
      input set,
      input clr_all,
      input clr_stop,
      output flags
   );
   modport ctrl (
      output set,
      output clr_all,
      output clr_stop,
      input flags
   );
endinterface

// ---- hdl/pin_sync3.sv ----
`timescale 1ns/100ps
module pin_sync3
   import isf_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic [2:0] d,
   output logic [2:0] q
);
   sync3_state_t st_ff;
   sync3_state_t nxt_st;

   // First stage feeds only the second stage
   always_comb begin
      nxt_st = st_ff;
      nxt_st.s1 = d;
      nxt_st.s2 = st_ff.s1;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_ff <= '0;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign q = st_ff.s2;
endmodule // pin_sync3

// ---- hdl/flag_bank.sv ----
`timescale 1ns/100ps
`include "isf_params.svh"
module flag_bank
   import isf_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   flag_if.bank fb
);
   flag_state_t st_ff;
   flag_state_t nxt_st;
   // A net, since each bit has its own generated driver
   wire [15:0] nxt_bits;
   localparam logic [15:0] LATCHED = `LATCHED_MASK;

   genvar i;
   generate
      for (i = 0; i < 16; i++) begin : g_bit
         if (LATCHED[i]) begin : g_latch
            logic clr;
            // Stop-found also clears on the start of a move
            assign clr = fb.clr_all |
               ((i == `BIT_STOP_FOUND) ? fb.clr_stop : 1'b0);
            // Set beats clear; held until cleared
            assign nxt_bits[i] = fb.set[i] |
               (st_ff.flags[i] & ~clr);
         end else begin : g_plain
            assign nxt_bits[i] = 1'b0;
         end
      end
   endgenerate

   always_comb begin
      nxt_st = st_ff;
      nxt_st.flags = nxt_bits;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_ff <= '0;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign fb.flags = st_ff.flags;
endmodule // flag_bank

// ---- hdl/internal_status_flags.sv ----
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "isf_params.svh"
module internal_status_flags
   import isf_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Pins
   input wire logic [2:0] io_line,
   input wire logic over_temp,
   input wire logic index_sensor,
   // Controller logic, same clock
   input wire logic [15:0] supply_level,
   input wire logic wait_expired,
   input wire logic stop_input_found,
   input wire logic move_start,
   input wire logic moving_state,
   input wire logic signed [15:0] position_error,
   input wire logic calc_valid,
   input wire logic signed [31:0] calc_result,
   // Results
   output logic [15:0] status_word,
   output logic poll_summary,
   output logic halt_event
);
   ctl_state_t st_ff;
   ctl_state_t nxt_st;
   logic [2:0] io_sync;
   logic [2:0] misc_sync;
   logic temp_sync;
   logic index_sync;
   logic [15:0] set_bits;
   logic [15:0] word;
   logic take;
   logic [16:0] err_mag;
   logic hold_err;
   logic move_err;
   logic [31:0] rd_val;

   flag_if fb();

   pin_sync3 u_io_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .d(io_line),
      .q(io_sync)
   );

   pin_sync3 u_misc_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .d({1'b0, index_sensor, over_temp}),
      .q(misc_sync)
   );

   assign temp_sync = misc_sync[0];
   assign index_sync = misc_sync[1];

   flag_bank u_flags (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .fb(fb.bank)
   );

   // Magnitude of a signed error, widened so -32768 stays exact
   function automatic logic [16:0] magnitude(
      input logic signed [15:0] e);
      logic [16:0] ext;
      ext = {e[15], e};
      magnitude = e[15] ? (~ext + 17'h00001) : ext;
   endfunction

   // Register read decode
   function automatic logic [31:0] reg_read(input logic [7:0] a,
      input ctl_state_t s);
      reg_read = `DATA32_ZERO;
      case (a)
         `OFS_STATUS: reg_read = {`HALF_ZERO, s.word};
         `OFS_MASK: reg_read = {17'h00000, s.mask};
         `OFS_POLL: reg_read = {`HALF_ZERO,
            9'h000, s.summary, 6'h00};
         `OFS_LV_THR: reg_read = {`HALF_ZERO, s.lv_thr};
         `OFS_OV_THR: reg_read = {`HALF_ZERO, s.ov_thr};
         `OFS_HOLD_LIM: reg_read = {`HALF_ZERO, s.hold_lim};
         `OFS_MOVE_LIM: reg_read = {`HALF_ZERO, s.move_lim};
         `OFS_DATA3: reg_read = {s.word, `HALF_ZERO};
         default: reg_read = `DATA32_ZERO;
      endcase
   endfunction

   // Error limit checks; the control state picks which limit applies
   assign err_mag = magnitude(position_error);
   assign hold_err = !moving_state &&
      (err_mag > {1'b0, st_ff.hold_lim});
   assign move_err = moving_state &&
      (err_mag > {1'b0, st_ff.move_lim});

   // Set terms for the latched bits
   always_comb begin
      set_bits = `WORD_RST;
      set_bits[`BIT_LOW_V] = supply_level < st_ff.lv_thr;
      set_bits[`BIT_OVER_V] = supply_level > st_ff.ov_thr;
      set_bits[`BIT_WAIT_DONE] = wait_expired;
      set_bits[`BIT_STOP_FOUND] = stop_input_found;
      set_bits[`BIT_HALT] = st_ff.halt_req;
      set_bits[`BIT_HOLD_ERR] = hold_err;
      set_bits[`BIT_MOVE_ERR] = move_err;
      set_bits[`BIT_INDEX] = index_sync;
   end

   assign fb.set = set_bits;
   assign fb.clr_all = st_ff.clr_req;
   assign fb.clr_stop = move_start;

   // Assemble the word: latched flags plus live conditions
   always_comb begin
      word = fb.flags & `LATCHED_MASK;
      word[`BIT_OVER_TEMP_N] = ~temp_sync;
      word[`BIT_IO3] = io_sync[2];
      word[`BIT_IO2] = io_sync[1];
      word[`BIT_IO1] = io_sync[0];
      word[`BIT_CALC_NEG] = st_ff.calc_neg;
      word[`BIT_CALC_POS] = st_ff.calc_pos;
      word[`BIT_CALC_ZERO] = st_ff.calc_zero;
      word[`BIT_RSVD] = 1'b0;
   end

   assign take = hsel && htrans[1] && hready && st_ff.hready;
   assign rd_val = reg_read(st_ff.pend_addr, st_ff);

   always_comb begin
      nxt_st = st_ff;
      nxt_st.clr_req = 1'b0;
      nxt_st.halt_req = 1'b0;
      // Calculation flags follow only the latest result
      if (calc_valid) begin
         nxt_st.calc_neg = calc_result[31];
         nxt_st.calc_pos = !calc_result[31] &&
            (calc_result != `DATA32_ZERO);
         nxt_st.calc_zero = calc_result == `DATA32_ZERO;
      end
      // One wait state per transfer, so a read never races a write
      if (take) begin
         nxt_st.pend = 1'b1;
         nxt_st.pend_write = hwrite;
         nxt_st.pend_addr = haddr[7:0];
         nxt_st.hready = 1'b0;
      end else if (st_ff.pend) begin
         nxt_st.pend = 1'b0;
         nxt_st.hready = 1'b1;
         nxt_st.hrdata = st_ff.pend_write ? `DATA32_ZERO : rd_val;
         if (st_ff.pend_write) begin
            case (st_ff.pend_addr)
               `OFS_CLEAR:
                  nxt_st.clr_req = hwdata[`CLEAR_GO_BIT];
               `OFS_MASK: nxt_st.mask = hwdata[14:0];
               `OFS_LV_THR: nxt_st.lv_thr = hwdata[15:0];
               `OFS_OV_THR: nxt_st.ov_thr = hwdata[15:0];
               `OFS_HOLD_LIM: nxt_st.hold_lim = hwdata[15:0];
               `OFS_MOVE_LIM: nxt_st.move_lim = hwdata[15:0];
               `OFS_HALT: nxt_st.halt_req = 1'b1;
               default: nxt_st.halt_req = 1'b0;
            endcase
         end
      end
      nxt_st.hresp = 1'b0;
      nxt_st.word = word;
      // Summary ORs every enabled condition of the word
      nxt_st.summary = |(word[14:0] & st_ff.mask);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_ff.mask <= `MASK_RST;
         st_ff.lv_thr <= `LV_THR_RST;
         st_ff.ov_thr <= `OV_THR_RST;
         st_ff.hold_lim <= `LIM_RST;
         st_ff.move_lim <= `LIM_RST;
         st_ff.calc_neg <= 1'b0;
         st_ff.calc_pos <= 1'b0;
         st_ff.calc_zero <= 1'b0;
         st_ff.clr_req <= 1'b0;
         st_ff.halt_req <= 1'b0;
         st_ff.pend <= 1'b0;
         st_ff.pend_write <= 1'b0;
         st_ff.pend_addr <= `OFS_STATUS;
         st_ff.hready <= 1'b1;
         st_ff.hrdata <= `DATA32_ZERO;
         st_ff.hresp <= 1'b0;
         st_ff.word <= `WORD_RST;
         st_ff.summary <= 1'b0;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign hrdata = st_ff.hrdata;
   assign hreadyout = st_ff.hready;
   assign hresp = st_ff.hresp;
   assign status_word = st_ff.word;
   assign poll_summary = st_ff.summary;
   assign halt_event = st_ff.halt_req;
endmodule // internal_status_flags

// ---- tb/internal_status_flags_assertions.sv ----
`timescale 1ns/100ps
module internal_status_flags_assertions (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [2:0] io_line,
   input wire logic over_temp,
   input wire logic wait_expired,
   input wire logic stop_input_found,
   input wire logic move_start,
   input wire logic [15:0] status_word,
   input wire logic poll_summary
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   logic [3:0] wr_age_ff;
   logic [3:0] nxt_wr_age;
   // Saturates so an old write never looks recent again
   always_comb begin
      nxt_wr_age = (wr_age_ff == 4'hF) ? wr_age_ff : wr_age_ff + 4'h1;
      if (hsel && htrans[1] && hwrite && hready) begin
         nxt_wr_age = 4'h0;
      end
   end
   always_ff @(posedge clk) begin
      wr_age_ff <= sys_rst ? 4'hF : nxt_wr_age;
   end
   sequence taken;
      hsel && htrans[1] && hready && hreadyout;
   endsequence
   sequence one_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   chk_bus_wait: assert property (taken |=> one_wait)
      else $error("bus wait state wrong");
   chk_wait_latch: assert property (
      wait_expired && ce |-> ##2 status_word[12])
      else $error("wait flag not set");
   chk_stop_latch: assert property (stop_input_found |-> ##2 status_word[11])
      else $error("stop flag not set");
   chk_move_clear: assert property (
      move_start && !stop_input_found |-> ##2 !status_word[11])
      else $error("stop flag not cleared by move");
   chk_latch_hold: assert property (
      !$past(sys_rst) && ($past(status_word) & ~status_word & 16'h7701)
      != 16'h0000 |-> wr_age_ff < 4'h8)
      else $error("latched flag dropped without clear");
   chk_temp_live: assert property (
      $stable(over_temp)[*5] |-> status_word[7] != over_temp)
      else $error("temperature bit wrong");
   chk_io_mirror: assert property (
      $stable(io_line)[*5] |-> status_word[6:4] == io_line)
      else $error("io bits wrong");
   chk_rsvd_zero: assert property (status_word[15] == 1'b0)
      else $error("reserved bit set");
   chk_summary_or: assert property (
      poll_summary |-> (status_word & 16'h7FFF) != 16'h0000
      || ($past(status_word) & 16'h7FFF) != 16'h0000)
      else $error("summary without condition");
endmodule // internal_status_flags_assertions

// ---- tb/host_model.sv ----
`timescale 1ns/100ps
module host_model (
   input wire logic clk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [31:0] hwdata
);
   initial begin
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0;
   end
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge clk);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge clk); while (!hready);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (!hready);
      q = hrdata;
      // Stale data would mask a slave that samples too late
      hwdata <= ~d;
   endtask
   // Without this, kill recovery would retrigger on old flags
   task clear_flags();
      logic [31:0] q;
      xfer(1'b1, 8'h04, 32'h1, q);
   endtask
   task poll(output logic [31:0] s);
      logic [31:0] q;
      xfer(1'b0, 8'h0C, 32'h0, q);
      s = 32'h0;
      if (q[6]) xfer(1'b0, 8'h00, 32'h0, s);
   endtask
endmodule // host_model

// ---- tb/internal_status_flags_tb.sv ----
`timescale 1ns/100ps
module internal_status_flags_tb;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans;
   logic hwrite, hreadyout, hresp, poll_summary, halt_event;
   logic [2:0] io_line = 3'b101;
   logic over_temp = 1'b0;
   logic ce = 1'b1;
   int halt_seen = 0;
   logic moving_state = 1'b0;
   logic [4:0] ev = 5'h00;
   logic [15:0] supply_level = 16'h0000;
   logic [15:0] status_word;
   logic signed [15:0] position_error = 16'sh0000;
   logic signed [31:0] calc_result = 32'sh0;
   logic [7:0] ofs[5] = '{8'h08, 8'h10, 8'h14, 8'h18, 8'h1C};
   logic [31:0] rv[5] = '{32'h0, 32'h0, 32'hFFFF, 32'hFFFF, 32'hFFFF};
   logic [31:0] cr[3] = '{32'hFFFFFFFB, 32'h7, 32'h0};
   logic [31:0] cb[3] = '{32'h8, 32'h4, 32'h2};
   int errors = 0;
   int cmp_count = 0;
   always #12.5 clk = ~clk;
   // Counts cycles of the one-cycle halt pulse
   always @(posedge clk) begin
      if (halt_event === 1'b1) halt_seen++;
   end
   internal_status_flags dut (.clk(clk), .sys_rst(sys_rst), .ce(ce),
      .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .io_line(io_line), .over_temp(over_temp), .index_sensor(ev[3]),
      .supply_level(supply_level), .wait_expired(ev[0]),
      .stop_input_found(ev[1]), .move_start(ev[2]),
      .moving_state(moving_state), .position_error(position_error),
      .calc_valid(ev[4]), .calc_result(calc_result),
      .status_word(status_word), .poll_summary(poll_summary),
      .halt_event(halt_event));
   host_model host (.clk(clk), .hready(hreadyout), .hrdata(hrdata),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));
   task complete_run();
      if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task check(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
      host.xfer(1'b0, a, 32'h0, q);
      check(n, q, e);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, q);
   endtask
   // Trailing wait covers pin sync plus the word register
   task pulse(input logic [4:0] m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 5'h00;
      repeat (4) @(posedge clk);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 5; i++) rd_chk("reset", ofs[i], rv[i]);
      rd_chk("status", 8'h00, 32'h00D0);
      rd_chk("unmapped", 8'hFC, 32'h0);
      wr(8'h00, 32'hFFFF);
      wr(8'h08, 32'hFFFF);
      rd_chk("mask", 8'h08, 32'h7FFF);
      rd_chk("status ro", 8'h00, 32'h00D0);
      wr(8'h10, 32'h20);
      wr(8'h14, 32'h5);
      wr(8'h18, 32'h10);
      wr(8'h1C, 32'h10);
      supply_level <= 16'h0010;
      position_error <= 16'sh0064;
      moving_state <= 1'b1;
      wr(8'h20, 32'h1);
      moving_state <= 1'b0;
      pulse(5'h0B);
      wr(8'h10, 32'h0);
      wr(8'h14, 32'hFFFF);
      position_error <= 16'sh0000;
      for (int i = 0; i < 3; i++) begin
         calc_result <= cr[i];
         pulse(5'h10);
         rd_chk("latched", 8'h00, 32'h7FD1 | cb[i]);
      end
      rd_chk("data3", 8'h24, 32'h7FD30000);
      wr(8'h08, 32'h0);
      rd_chk("poll off", 8'h0C, 32'h0);
      wr(8'h08, 32'h1000);
      host.poll(q);
      check("poll", q, 32'h7FD3);
      check("summary", {31'h0, poll_summary}, 32'h1);
      pulse(5'h04);
      rd_chk("move", 8'h00, 32'h77D3);
      host.clear_flags();
      repeat (3) @(posedge clk);
      rd_chk("cleared", 8'h00, 32'h00D2);
      over_temp <= 1'b1;
      io_line <= 3'b010;
      repeat (6) @(posedge clk);
      rd_chk("live", 8'h00, 32'h0022);
      // Clock enable low must swallow an event
      ce <= 1'b0;
      pulse(5'h01);
      ce <= 1'b1;
      repeat (3) @(posedge clk);
      rd_chk("frozen", 8'h00, 32'h0022);
      check("hresp", {31'h0, hresp}, 32'h0);
      check("halt pulse", halt_seen, 32'h1);
      complete_run();
   end
   initial begin
      repeat (5000) @(posedge clk);
      errors++;
      complete_run();
   end
endmodule // internal_status_flags_tb
bind internal_status_flags internal_status_flags_assertions chk (
   .clk(clk), .sys_rst(sys_rst), .ce(ce), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .io_line(io_line), .over_temp(over_temp), .wait_expired(wait_expired),
   .stop_input_found(stop_input_found), .move_start(move_start),
   .status_word(status_word), .poll_summary(poll_summary));
